// >>> hw/dsd_strobe_delay_control.sv
// The implementer's own choices: the Avalon-MM register port and the register addresses.
module dsd_strobe_delay_control
	import dsd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic readStrobeClk,
	input wire logic strobeComp,
	input wire logic [DQ_W-1:0] dqIn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [CODE_W-1:0] strobeDelayCalCode,
	output logic delayedReadStrobeClock,
	output logic capturePolarity,
	output logic gearboxTransferLatch,
	output logic outputGearClockA,
	output logic outputGearClockB,
	output logic leveledWriteStrobeClock
);

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	dsd_ctrl_t ctrl;
	logic [DYN_W-1:0] writeLevelDynamicDelay;
	logic [CODE_W-1:0] dllTarget [2];
	logic [CODE_W-1:0] calCode [2];
	logic dllLock [2];
	logic readActive;
	logic writeActive;
	logic [2*DQ_W-1:0] captureWord;
	dsd_status_t status;
	logic writeHit;

	assign writeHit = avs_write && !avs_waitrequest;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
			writeLevelDynamicDelay <= DYN_RESET;
			dllTarget[0] <= TARGET_RESET;
			dllTarget[1] <= TARGET_RESET;
		end else if (writeHit) begin
			unique case (avs_address)
				REG_CTRL: begin
					ctrl <= avs_writedata[CTRL_W-1:0];
				end
				REG_DYN_DELAY: begin
					// Chosen by the core controller during leveling  see [R15]
					writeLevelDynamicDelay <= avs_writedata[DYN_W-1:0];
				end
				REG_LEFT_TARGET: begin
					dllTarget[0] <= avs_writedata[CODE_W-1:0];
				end
				REG_RIGHT_TARGET: begin
					dllTarget[1] <= avs_writedata[CODE_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		status = '0;
		status.leftLock = dllLock[0];
		status.rightLock = dllLock[1];
		status.readActive = readActive;
		status.writeActive = writeActive;
		status.leftCode = calCode[0];
		status.rightCode = calCode[1];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then the access completes

	logic [31:0] next_readdata;

	// Unmapped offsets read as zero
	always_comb begin
		unique case (avs_address)
			REG_CTRL: next_readdata = {23'h000000, ctrl};
			REG_DYN_DELAY: next_readdata = {24'h000000, writeLevelDynamicDelay};
			REG_LEFT_TARGET: next_readdata = {25'h0000000, dllTarget[0]};
			REG_RIGHT_TARGET: next_readdata = {25'h0000000, dllTarget[1]};
			REG_STATUS: next_readdata = {14'h0000, status};
			REG_CAPTURE: next_readdata = {12'h000, captureWord};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= next_readdata;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two delay-locked loops, one per device half

	for (genvar i = 0; i < 2; i++) begin : g_dll
		dsd_dll_state_t dllState;
		logic [3:0] updateTimer;
		logic [2:0] matchCount;
		logic updateTick;

		assign updateTick = (updateTimer == DLL_UPDATE_CYCLES - 4'h1);

		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				updateTimer <= 4'h0;
			end else if (updateTick) begin
				updateTimer <= 4'h0;
			end else begin
				updateTimer <= updateTimer + 4'h1;
			end
		end

		// Phase detector stand-in: step the code one unit toward the target  see [R07]
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				calCode[i] <= CODE_RESET;
			end else if (updateTick && calCode[i] < dllTarget[i]) begin
				calCode[i] <= calCode[i] + 7'h01;
			end else if (updateTick && calCode[i] > dllTarget[i]) begin
				calCode[i] <= calCode[i] - 7'h01;
			end
		end

		// Lock only after the code has matched for several updates  see [R17]
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				matchCount <= 3'h0;
				dllState <= DLL_TRACK;
			end else if (updateTick) begin
				unique case (dllState)
					DLL_TRACK: begin
						if (calCode[i] != dllTarget[i]) begin
							matchCount <= 3'h0;
						end else if (matchCount == DLL_LOCK_HOLD - 3'h1) begin
							dllState <= DLL_LOCKED;
						end else begin
							matchCount <= matchCount + 3'h1;
						end
					end
					DLL_LOCKED: begin
						if (calCode[i] != dllTarget[i]) begin
							matchCount <= 3'h0;
							dllState <= DLL_TRACK;
						end
					end
				endcase
			end
		end

		assign dllLock[i] = (dllState == DLL_LOCKED);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Group side and mode qualification

	logic sideLeft;
	logic sideRight;
	logic groupLock;
	logic edgeHasDdr;
	logic edgeHasGearing;
	logic [CODE_W-1:0] selCode;

	assign sideLeft = LEFT_BANK_MASK[ctrl.bank];   // see [R06]
	assign sideRight = RIGHT_BANK_MASK[ctrl.bank];   // see [R06]
	assign groupLock = (sideLeft && dllLock[0]) || (sideRight && dllLock[1]);
	assign edgeHasDdr = (ctrl.edgeSel != EDGE_BOTTOM);   // see [R03]
	assign edgeHasGearing = edgeHasDdr && (ctrl.edgeSel != EDGE_TOP);   // see [R04]
	assign selCode = sideLeft ? calCode[0] : (sideRight ? calCode[1] : CODE_RESET);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strobeDelayCalCode <= CODE_RESET;
			readActive <= 1'b0;
			writeActive <= 1'b0;
		end else begin
			strobeDelayCalCode <= selCode;   // see [R06]
			readActive <= ctrl.readEnable && edgeHasDdr && groupLock;   // see [R17]
			writeActive <= ctrl.writeEnable && edgeHasGearing && groupLock;   // see [R17]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read strobe delay line on the dedicated strobe pin

	logic [1:0] strobeTrueSync;
	logic [1:0] strobeCompSync;
	logic strobeLevel;
	logic [READ_TAPS-1:0] readHistory;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strobeTrueSync <= 2'h0;
			strobeCompSync <= 2'h0;
		end else begin
			strobeTrueSync <= {strobeTrueSync[0], readStrobeClk};   // see [R01]
			strobeCompSync <= {strobeCompSync[0], strobeComp};
		end
	end

	// True and complement pins feed one shared control path  see [R02]
	assign strobeLevel = ctrl.differential ? (strobeTrueSync[1] && !strobeCompSync[1])
		: strobeTrueSync[1];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			readHistory <= '0;
		end else begin
			readHistory <= {readHistory[READ_TAPS-2:0], strobeLevel};
		end
	end

	// Delayed strobe leaves only on its own dedicated port  see [R16]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			delayedReadStrobeClock <= 1'b0;
		end else begin
			delayedReadStrobeClock <= readActive && readHistory[selCode];   // see [R08]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write side: gear clocks and leveled write strobe

	logic [1:0] gearPhase;
	logic [WRITE_TAPS-1:0] writeHistory;
	logic [7:0] writeTap;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gearPhase <= 2'h0;
			outputGearClockA <= 1'b0;
			outputGearClockB <= 1'b0;
		end else if (!writeActive) begin
			// Park the phase so the first gear pulse after enable is full width
			gearPhase <= 2'h0;
			outputGearClockA <= 1'b0;
			outputGearClockB <= 1'b0;
		end else begin
			gearPhase <= gearPhase + 2'h1;
			// Quadrature pair so data and strobe registers sit a quarter apart  see [R11]
			outputGearClockA <= writeActive && gearPhase[1];
			outputGearClockB <= writeActive && (gearPhase[1] ^ gearPhase[0]);
		end
	end

	// Low seven bits add up to 127 steps on top of the code  see [R13]
	assign writeTap = {1'b0, selCode} + {1'b0, writeLevelDynamicDelay[DYN_W-2:0]};

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			writeHistory <= '0;
		end else begin
			writeHistory <= {writeHistory[WRITE_TAPS-2:0], outputGearClockA};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			leveledWriteStrobeClock <= 1'b0;
		end else begin
			leveledWriteStrobeClock <= writeActive   // see [R12]
				&& (writeHistory[writeTap] ^ writeLevelDynamicDelay[DYN_W-1]);   // see [R14]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: capture on the received strobe

	logic [1:0] linkActiveSync;
	logic [1:0] linkGearboxSync;
	logic [DQ_W-1:0] firstStage;
	logic [2*DQ_W-1:0] secondStage;
	logic linkToggle;
	logic [1:0] linkResetSync;
	logic linkRst;

	// Reset leaves the link domain on its own clock, two strobe edges late
	always_ff @(posedge readStrobeClk or posedge rst) begin
		if (rst) begin
			linkResetSync <= 2'h3;
		end else begin
			linkResetSync <= {linkResetSync[0], 1'b0};
		end
	end

	// Every link register below is reset by this
	assign linkRst = linkResetSync[1];

	always_ff @(posedge readStrobeClk or posedge linkRst) begin
		if (linkRst) begin
			linkActiveSync <= 2'h0;
			linkGearboxSync <= 2'h0;
		end else begin
			linkActiveSync <= {linkActiveSync[0], readActive};
			linkGearboxSync <= {linkGearboxSync[0], ctrl.gearboxMode};
		end
	end

	// Polarity alternates each strobe cycle to steer the sync registers  see [R09]
	always_ff @(posedge readStrobeClk or posedge linkRst) begin
		if (linkRst) begin
			capturePolarity <= 1'b0;
		end else if (linkActiveSync[1]) begin
			capturePolarity <= !capturePolarity;
		end else begin
			capturePolarity <= 1'b0;
		end
	end

	// The strobe itself clocks the ten data bits in  see [R05]
	always_ff @(posedge readStrobeClk or posedge linkRst) begin
		if (linkRst) begin
			firstStage <= '0;
			secondStage <= '0;
			linkToggle <= 1'b0;
		end else if (linkActiveSync[1]) begin
			firstStage <= dqIn;
			if (capturePolarity) begin
				secondStage <= {firstStage, dqIn};
				linkToggle <= !linkToggle;
			end
		end
	end

	always_ff @(posedge readStrobeClk or posedge linkRst) begin
		if (linkRst) begin
			gearboxTransferLatch <= 1'b0;
		end else begin
			// Moves the first register pair into the second stage  see [R10]
			gearboxTransferLatch <= linkActiveSync[1] && linkGearboxSync[1] && !capturePolarity;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Captured word crosses back by toggle; word is held two strobe cycles

	logic [2:0] toggleSync;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			toggleSync <= 3'h0;
		end else begin
			toggleSync <= {toggleSync[1:0], linkToggle};
		end
	end

	// Load once per toggle edge; the second stage is steady by then
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			captureWord <= '0;
		end else if (toggleSync[2] != toggleSync[1]) begin
			captureWord <= secondStage;
		end
	end

endmodule : dsd_strobe_delay_control

// >>> hw/dsd_pkg.sv
// Contract
// [R01] One dedicated strobe pin per twelve-cell group
// [R02] Differential strobe pair shares one control block
// [R03] Bottom edge offers no DDR capture modes
// [R04] Top edge lacks output gearing, no writes
// [R05] Strobe clocks ten-bit read data into registers
// [R06] Two loops; banks 0,7,6 left, 1,2,3 right
// [R07] Loop tracks drift, outputs seven-bit calibration code
// [R08] Read strobe delayed by code, fed to pads
// [R09] Read control produces capture polarity signal
// [R10] Gearbox mode produces stage transfer latch pulse
// [R11] Write control produces two output gear clocks
// [R12] Write strobe delay is code plus dynamic setting
// [R13] Dynamic delay low bits give 128 steps
// [R14] Dynamic delay top bit inverts, half-period shift
// [R15] Core controller runs leveling, picks dynamic delay
// [R16] Strobe reaches dedicated routing through control block
// [R17] Strobe paths invalid until loop holds steady code
package dsd_pkg;

	localparam int GROUP_CELLS = 12;
	localparam int DQ_W = 10;
	localparam int CODE_W = 7;
	localparam int DYN_W = 8;
	localparam int CTRL_W = 9;
	localparam int READ_TAPS = 128;
	localparam int WRITE_TAPS = 256;

	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_DYN_DELAY = 6'h04;
	localparam logic [5:0] REG_LEFT_TARGET = 6'h08;
	localparam logic [5:0] REG_RIGHT_TARGET = 6'h0c;
	localparam logic [5:0] REG_STATUS = 6'h10;
	localparam logic [5:0] REG_CAPTURE = 6'h14;

	localparam logic [1:0] EDGE_LEFT = 2'h0;
	localparam logic [1:0] EDGE_RIGHT = 2'h1;
	localparam logic [1:0] EDGE_TOP = 2'h2;
	localparam logic [1:0] EDGE_BOTTOM = 2'h3;

	localparam logic [7:0] LEFT_BANK_MASK = 8'hc1;
	localparam logic [7:0] RIGHT_BANK_MASK = 8'h0e;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
	localparam logic [DYN_W-1:0] DYN_RESET = 8'h00;
	localparam logic [CODE_W-1:0] TARGET_RESET = 7'h20;
	localparam logic [CODE_W-1:0] CODE_RESET = 7'h00;

	localparam logic [3:0] DLL_UPDATE_CYCLES = 4'h8;
	localparam logic [2:0] DLL_LOCK_HOLD = 3'h4;

	typedef struct packed {
		logic [2:0] bank;
		logic [1:0] edgeSel;
		logic differential;
		logic gearboxMode;
		logic writeEnable;
		logic readEnable;
	} dsd_ctrl_t;

	typedef struct packed {
		logic [CODE_W-1:0] rightCode;
		logic [CODE_W-1:0] leftCode;
		logic writeActive;
		logic readActive;
		logic rightLock;
		logic leftLock;
	} dsd_status_t;

	typedef enum logic [1:0] {
		DLL_TRACK = 2'b01,
		DLL_LOCKED = 2'b10
	} dsd_dll_state_t;

endpackage : dsd_pkg

// >>> verification/dsd_properties.sv
module dsd_properties
	import dsd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic outputGearClockA,
	input wire logic outputGearClockB
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_answer: assert property (p_answer) else $error("bus answer late");
	property p_oneCycle; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_oneCycle: assert property (p_oneCycle) else $error("wait low too long");
	property p_onRequest; !avs_waitrequest |-> $past(avs_read) || $past(avs_write); endproperty
	a_onRequest: assert property (p_onRequest) else $error("answer without request");
	property p_dataHold;
		!(avs_read || avs_write) && avs_waitrequest |=> $stable(avs_readdata);
	endproperty
	a_dataHold: assert property (p_dataHold) else $error("read data moved");
	property p_bLeads; !outputGearClockA && outputGearClockB |=> outputGearClockA || !outputGearClockB;
	endproperty
	a_bLeads: assert property (p_bLeads) else $error("gear A late");
	property p_aHigh2; $rose(outputGearClockA) |=> outputGearClockA || !outputGearClockB; endproperty
	a_aHigh2: assert property (p_aHigh2) else $error("gear A short");
	property p_aDrop; outputGearClockA && !outputGearClockB |=> !outputGearClockA; endproperty
	a_aDrop: assert property (p_aDrop) else $error("gear A long");
	property p_aFall; $fell(outputGearClockA) |-> !outputGearClockB; endproperty
	a_aFall: assert property (p_aFall) else $error("gear phase wrong");
	c_read: cover property (avs_read && !avs_waitrequest);
	c_write: cover property (avs_write && !avs_waitrequest);
	c_gear: cover property ($rose(outputGearClockA));
endmodule : dsd_properties
////////////////////////////////////////
bind dsd_strobe_delay_control dsd_properties u_props (.sys_clk, .rst, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .outputGearClockA, .outputGearClockB);

// >>> verification/dsd_memory_model.sv
module dsd_memory_model
	import dsd_pkg::*;
(
	output logic readStrobeClk,
	output logic strobeComp,
	output logic [DQ_W-1:0] dqIn
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		readStrobeClk = 1'b0;
		strobeComp = 1'b1;
		dqIn = '0;
	end
	// Strobe parks low between bursts; released data shows the inverse word
	task automatic burst(input logic [DQ_W-1:0] w[$]);
		#13;
		foreach (w[i]) begin
			dqIn = w[i];
			#20 readStrobeClk = 1'b1;
			strobeComp = 1'b0;
			#40 readStrobeClk = 1'b0;
			strobeComp = 1'b1;
			#20;
		end
		dqIn = ~dqIn;
	endtask : burst
endmodule : dsd_memory_model

// >>> verification/dsd_strobe_delay_control_bench.sv
module dsd_strobe_delay_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import dsd_pkg::*;
	logic sys_clk, rst, readStrobeClk, strobeComp, avs_read, avs_write, avs_waitrequest;
	logic [DQ_W-1:0] dqIn;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, got, seed, r;
	logic [CODE_W-1:0] strobeDelayCalCode;
	logic delayedReadStrobeClock, capturePolarity, gearboxTransferLatch;
	logic outputGearClockA, outputGearClockB, leveledWriteStrobeClock, lvlOn, lvlInv;
	int miscompares, compares, lt, rt, latchN, polN, dlyN, aN, lvlDly;
	logic [DQ_W-1:0] w[$];
	logic aHist[$];
	logic [31:0] ctrls[4] = '{32'h5, 32'hd, 32'h1, 32'h31};
	logic [7:0] dyns[4] = '{8'h00, 8'h7f, 8'h80, 8'h00};
	dsd_strobe_delay_control dut (.sys_clk, .rst, .readStrobeClk, .strobeComp, .dqIn,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.strobeDelayCalCode, .delayedReadStrobeClock, .capturePolarity, .gearboxTransferLatch,
		.outputGearClockA, .outputGearClockB, .leveledWriteStrobeClock);
	dsd_memory_model mem (.readStrobeClk, .strobeComp, .dqIn);
	////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge gearboxTransferLatch) latchN++;
	always @(posedge capturePolarity) polN++;
	always @(posedge delayedReadStrobeClock) dlyN++;
	always @(posedge outputGearClockA) aN++;
	always @(negedge sys_clk) begin
		aHist.push_front(outputGearClockA);
		if (aHist.size() > 300) void'(aHist.pop_back());
		// The tapped history passes two registers before the pin
		if (lvlOn) chk(leveledWriteStrobeClock, aHist[lvlDly + 2] ^ lvlInv);
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		got = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic stop_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	////////////////////////////////////////
	initial begin
		seed = 32'h000086b6;
		rst = 1'b1;
		{avs_read, avs_write, lvlOn, avs_address, avs_writedata} = '0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		chk(strobeDelayCalCode, 0);
		bus(1, 6'h3c, '1);
		bus(0, 6'h3c, 0);
		chk(got, 0);
		bus(0, REG_LEFT_TARGET, 0);
		chk(got, 32'h20);
		r = rnd();
		lt = 3 + r[2:0];
		rt = lt + 2;
		bus(1, REG_LEFT_TARGET, lt);
		bus(1, REG_RIGHT_TARGET, rt);
		repeat (100) begin
			bus(0, REG_STATUS, 0);
			if (got[1:0] === 2'b11) break;
		end
		chk(got[1:0], 2'b11);
		chk(got[17:4], {rt[6:0], lt[6:0]});
		for (int b = 0; b < 8; b++) begin
			bus(1, REG_CTRL, b << 6 | 1);
			repeat (2) @(posedge sys_clk);
			chk(strobeDelayCalCode, b inside {0, 6, 7} ? lt : b inside {1, 2, 3} ? rt : 0);
		end
		$display("bank test done");
		foreach (ctrls[m]) begin
			bus(1, REG_CTRL, ctrls[m]);
			w = {};
			repeat (10) w.push_back(DQ_W'(rnd()));
			mem.burst(w[0:3]);
			repeat (20) @(posedge sys_clk);
			bus(0, REG_CAPTURE, 0);
			r = got;
			latchN = 0;
			polN = 0;
			dlyN = 0;
			mem.burst(w[4:9]);
			repeat (20) @(posedge sys_clk);
			bus(0, REG_CAPTURE, 0);
			chk(latchN, ctrls[m][2] ? 3 : 0);
			chk(dlyN, m < 3 ? 6 : 0);
			chk(polN, m < 3 ? 3 : 0);
			chk(got[19:0], m < 3 ? {w[8], w[9]} : r[19:0]);
		end
		$display("read test done");
		r = rnd();
		dyns[3] = r[7:0];
		bus(1, REG_CTRL, 32'h3);
		foreach (dyns[i]) begin
			bus(1, REG_DYN_DELAY, dyns[i]);
			repeat (300) @(posedge sys_clk);
			lvlDly = lt + dyns[i][6:0];
			lvlInv = dyns[i][7];
			aN = 0;
			lvlOn = 1'b1;
			repeat (40) @(posedge sys_clk);
			lvlOn = 1'b0;
			chk(aN, 10);
		end
		bus(1, REG_CTRL, 32'h23);
		repeat (20) @(posedge sys_clk);
		aN = 0;
		repeat (40) @(posedge sys_clk);
		chk(aN, 0);
		chk(leveledWriteStrobeClock, 0);
		$display("write test done");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		stop_test();
	end
endmodule : dsd_strobe_delay_control_bench
